// file: core/fma_regs.vh
// Purpose: Constants for the frame memory access and colour table loader
// Assumes: Host bytes arrive as one-cycle strobes synchronous to clk_sys
// Notes: Functional notes below
//
// Functional notes
// - Command 2Ch enters frame-write mode; later data bytes are pixel bytes.
// - Frame-write command reloads column and row counters with start values.
// - Start corner chosen by the current access order setting.
// - Each write byte is stored at the counter position, then counters advance.
// - Any other command byte ends an ongoing frame write.
// - Write data length is unlimited in every colour mode.
// - Frame commands change no other driver state.
// - Frame memory is not cleared by hardware or software reset.
// - Command 2Eh enters frame-read; first read is dummy, then memory data.
// - Frame-read command reloads column and row counters with start values.
// - Counters advance after each read byte except the dummy, in the write order.
// - Any other command ends an ongoing frame read.
// - Readback is 16-bit when depth select is 0, 18-bit when 1.
// - Command 2Dh takes 48 bytes: 16 red, 16 green, 16 blue entries.
// - Colour table expands 8- and 12-bit pixels to 16-bit depth.
// - Table load leaves settings and frame memory untouched.
// - Software reset keeps the table; hardware reset restores defaults.
// - Row start and end in force at frame-write start are used.
`ifndef FMA_REGS_VH
`define FMA_REGS_VH
`define FMA_CMD_FRAME_WRITE 8'h2c
`define FMA_CMD_FRAME_READ 8'h2e
`define FMA_CMD_LUT_LOAD 8'h2d
`define FMA_LUT_BYTES 6'h30
`define FMA_LUT_GREEN_BASE 6'h10
`define FMA_LUT_BLUE_BASE 6'h20
`define FMA_MODE_IDLE 2'h0
`define FMA_MODE_WRITE 2'h1
`define FMA_MODE_READ 2'h2
`define FMA_MODE_LUT 2'h3
`define FMA_ORD_ROWREV 0
`define FMA_ORD_COLREV 1
`define FMA_ORD_SWAP 2
`endif

// file: core/fma_fifo.v
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes: Full and empty derived from an occupancy count
module fma_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Fill side
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output wire inReady,
  // Drain side
  output wire outValid,
  output wire [WIDTH-1:0] outData,
  input wire outReady
);
  reg [WIDTH-1:0] memArr [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire doPush;
  wire doPop;

  assign inReady = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = memArr[rdPtr_ff];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always @(posedge clk_sys) begin
    if (doPush) begin
      memArr[wrPtr_ff] <= inData;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// file: core/fma_frame_access.v
// Purpose: Frame memory write/read and colour table load command handling
// Assumes: Host strobes are one-cycle pulses synchronous to clk_sys
// Notes: Write bytes pass a FIFO before memory; frame memory has no reset
`include "fma_regs.vh"
module fma_frame_access #(
  parameter COL_W = 8,
  parameter ROW_W = 8,
  parameter NUM_COLS = 176,
  parameter NUM_ROWS = 240,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  input wire swRst,
  // Host byte interface
  input wire dataCmdSelect,
  input wire wrStrobe,
  input wire rdStrobe,
  input wire [7:0] hostData,
  output wire wrReady,
  output reg [7:0] rdData_ff,
  output reg rdValid_ff,
  // Configuration
  input wire [COL_W-1:0] colStart,
  input wire [COL_W-1:0] colEnd,
  input wire [ROW_W-1:0] rowStart,
  input wire [ROW_W-1:0] rowEnd,
  input wire [2:0] accessOrderControl,
  input wire colourDepthSelect,
  input wire [1:0] pixelFormat,
  // Colour table lookup port
  input wire [1:0] lutSel,
  input wire [3:0] lutIdx,
  output reg [5:0] lutEntry_ff,
  // Status
  output wire [1:0] mode,
  output wire [COL_W-1:0] colPos,
  output wire [ROW_W-1:0] rowPos
);
  localparam MEM_DEPTH = NUM_COLS * NUM_ROWS * 3;
  localparam LUT_ENTRIES = 48;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0] mode_ff;
  reg [1:0] nxt_mode;
  reg [COL_W-1:0] col_ff;
  reg [ROW_W-1:0] row_ff;
  reg [1:0] sub_ff;
  reg dummyDone_ff;
  reg [5:0] lutCnt_ff;
  reg [5:0] lutArr [0:LUT_ENTRIES-1];
  reg [7:0] frameMem [0:MEM_DEPTH-1];
  reg [COL_W-1:0] wCol_ff;
  reg [ROW_W-1:0] wRow_ff;
  reg [1:0] wSub_ff;
  reg [COL_W-1:0] wColS_ff;
  reg [COL_W-1:0] wColE_ff;
  reg [ROW_W-1:0] wRowS_ff;
  reg [ROW_W-1:0] wRowE_ff;
  reg [2:0] wOrd_ff;
  reg [1:0] bpp_ff;
  integer i;

  wire isCmd;
  wire isData;
  wire fifoOutValid;
  wire [7:0] fifoOutData;
  wire rdMode;

  // Shared decode and address terms
  wire rdAccept;
  wire [1:0] rdLastSub;
  wire rdPixelEnd;
  wire rdColLast;
  wire rdRowLast;
  wire [COL_W-1:0] rdPhysCol;
  wire [ROW_W-1:0] rdPhysRow;
  wire [31:0] rdAddr;
  wire wrPixelEnd;
  wire wrColLast;
  wire wrRowLast;
  wire [COL_W-1:0] wrPhysCol;
  wire [ROW_W-1:0] wrPhysRow;
  wire [31:0] wrAddr;
  wire wrCmdSeen;
  wire frameCmdSeen;
  wire lutCmdSeen;
  wire lutByte;
  wire lutLastByte;
  wire memWrEn;

  assign isCmd = wrStrobe && !dataCmdSelect;
  assign isData = wrStrobe && dataCmdSelect;
  assign mode = mode_ff;
  assign colPos = col_ff;
  assign rowPos = row_ff;
  assign rdMode = (mode_ff == `FMA_MODE_READ);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Physical column from logical counter under the access order
  function [COL_W-1:0] physCol;
    input [COL_W-1:0] c;
    input [ROW_W-1:0] r;
    input [2:0] ord;
    reg [COL_W-1:0] t;
    begin
      t = ord[`FMA_ORD_SWAP] ? r[COL_W-1:0] : c;
      physCol = ord[`FMA_ORD_COLREV] ? (NUM_COLS[COL_W-1:0] - 1'b1 - t) : t;
    end
  endfunction

  function [ROW_W-1:0] physRow;
    input [COL_W-1:0] c;
    input [ROW_W-1:0] r;
    input [2:0] ord;
    reg [ROW_W-1:0] t;
    begin
      t = ord[`FMA_ORD_SWAP] ? c[ROW_W-1:0] : r;
      physRow = ord[`FMA_ORD_ROWREV] ? (NUM_ROWS[ROW_W-1:0] - 1'b1 - t) : t;
    end
  endfunction

  function [31:0] memAddr;
    input [COL_W-1:0] pc;
    input [ROW_W-1:0] pr;
    input [1:0] sb;
    begin
      memAddr = (pr * NUM_COLS + pc) * 3 + sb;
    end
  endfunction

  // Bytes per pixel for a format code
  function [1:0] bytesPer;
    input [1:0] fmt;
    begin
      bytesPer = (fmt == 2'h2) ? 2'h3 : ((fmt == 2'h0) ? 2'h1 : 2'h2);
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode and address terms used by the processes below
  // ----------------------------------------------------------------
  assign wrCmdSeen = isCmd && (hostData == `FMA_CMD_FRAME_WRITE);
  assign frameCmdSeen = isCmd && (hostData == `FMA_CMD_FRAME_WRITE ||
                                  hostData == `FMA_CMD_FRAME_READ);
  assign lutCmdSeen = isCmd && (hostData == `FMA_CMD_LUT_LOAD);
  assign lutByte = (mode_ff == `FMA_MODE_LUT) && isData;
  assign lutLastByte = lutByte && (lutCnt_ff == `FMA_LUT_BYTES - 1'b1);
  assign rdAccept = rdMode && rdStrobe && dataCmdSelect;
  // Readback is always 2 or 3 bytes per pixel, whatever the write format
  assign rdLastSub = colourDepthSelect ? 2'h2 : 2'h1;
  assign rdPixelEnd = (sub_ff == rdLastSub);
  assign rdColLast = (col_ff == colEnd);
  assign rdRowLast = (row_ff == rowEnd);
  assign rdPhysCol = physCol(col_ff, row_ff, accessOrderControl);
  assign rdPhysRow = physRow(col_ff, row_ff, accessOrderControl);
  assign rdAddr = memAddr(rdPhysCol, rdPhysRow, sub_ff);
  assign wrPixelEnd = (wSub_ff == bpp_ff - 1'b1);
  assign wrColLast = (wCol_ff == wColE_ff);
  assign wrRowLast = (wRow_ff == wRowE_ff);
  assign wrPhysCol = physCol(wCol_ff, wRow_ff, wOrd_ff);
  assign wrPhysRow = physRow(wCol_ff, wRow_ff, wOrd_ff);
  assign wrAddr = memAddr(wrPhysCol, wrPhysRow, wSub_ff);
  // Memory writes are held off while either reset is applied
  assign memWrEn = fifoOutValid && !sys_rst && !swRst;

  // ----------------------------------------------------------------
  // Write data FIFO
  // ----------------------------------------------------------------
  // The drain side never stalls: one byte a cycle reaches memory, so the
  // FIFO only absorbs bursts and a host that waits on wrReady loses nothing
  fma_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .inValid(isData && (mode_ff == `FMA_MODE_WRITE)),
    .inData(hostData),
    .inReady(wrReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(1'b1)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always @* begin
    nxt_mode = mode_ff;
    if (isCmd) begin
      case (hostData)
        `FMA_CMD_FRAME_WRITE: nxt_mode = `FMA_MODE_WRITE;
        `FMA_CMD_FRAME_READ: nxt_mode = `FMA_MODE_READ;
        `FMA_CMD_LUT_LOAD: nxt_mode = `FMA_MODE_LUT;
        default: nxt_mode = `FMA_MODE_IDLE;
      endcase
    end else if (lutLastByte) begin
      nxt_mode = `FMA_MODE_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Host-side counters (read path and status)
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst || swRst) begin
      mode_ff <= `FMA_MODE_IDLE;
      col_ff <= {COL_W{1'b0}};
      row_ff <= {ROW_W{1'b0}};
      sub_ff <= 2'h0;
      dummyDone_ff <= 1'b0;
      lutCnt_ff <= 6'h00;
      rdValid_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end else begin
      mode_ff <= nxt_mode;
      rdValid_ff <= 1'b0;
      if (frameCmdSeen) begin
        col_ff <= colStart;
        row_ff <= rowStart;
        sub_ff <= 2'h0;
        dummyDone_ff <= 1'b0;
      end
      if (lutCmdSeen) begin
        lutCnt_ff <= 6'h00;
      end else if (lutByte) begin
        lutCnt_ff <= lutCnt_ff + 1'b1;
      end
      // Bytes still queued in the write FIFO are not yet visible to a read
      // issued at once; the host leaves a few cycles after its last write byte
      if (rdAccept) begin
        rdValid_ff <= 1'b1;
        if (!dummyDone_ff) begin
          rdData_ff <= 8'h00;
          dummyDone_ff <= 1'b1;
        end else begin
          rdData_ff <= frameMem[rdAddr];
          if (rdPixelEnd) begin
            sub_ff <= 2'h0;
            if (rdColLast) begin
              col_ff <= colStart;
              row_ff <= rdRowLast ? rowStart : row_ff + 1'b1;
            end else begin
              col_ff <= col_ff + 1'b1;
            end
          end else begin
            sub_ff <= sub_ff + 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory-side write counters, window latched at command
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst || swRst) begin
      wCol_ff <= {COL_W{1'b0}};
      wRow_ff <= {ROW_W{1'b0}};
      wSub_ff <= 2'h0;
      wColS_ff <= {COL_W{1'b0}};
      wColE_ff <= {COL_W{1'b0}};
      wRowS_ff <= {ROW_W{1'b0}};
      wRowE_ff <= {ROW_W{1'b0}};
      wOrd_ff <= 3'h0;
      bpp_ff <= 2'h1;
    end else if (wrCmdSeen) begin
      // Window, order and format are latched so later settings cannot move a write
      wCol_ff <= colStart;
      wRow_ff <= rowStart;
      wSub_ff <= 2'h0;
      wColS_ff <= colStart;
      wColE_ff <= colEnd;
      wRowS_ff <= rowStart;
      wRowE_ff <= rowEnd;
      wOrd_ff <= accessOrderControl;
      bpp_ff <= bytesPer(pixelFormat);
    end else if (fifoOutValid) begin
      // No length limit: counters simply wrap
      if (wrPixelEnd) begin
        wSub_ff <= 2'h0;
        if (wrColLast) begin
          wCol_ff <= wColS_ff;
          wRow_ff <= wrRowLast ? wRowS_ff : wRow_ff + 1'b1;
        end else begin
          wCol_ff <= wCol_ff + 1'b1;
        end
      end else begin
        wSub_ff <= wSub_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame memory: no reset term, contents survive both resets
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (memWrEn) begin
      frameMem[wrAddr] <= fifoOutData;
    end
  end

  // ----------------------------------------------------------------
  // Colour table: hardware reset restores ramp defaults
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      for (i = 0; i < LUT_ENTRIES; i = i + 1) begin
        if (i < 16) begin
          lutArr[i] <= i[5:0] << 1;
        end else if (i < 32) begin
          lutArr[i] <= (i[5:0] - `FMA_LUT_GREEN_BASE) << 2;
        end else begin
          lutArr[i] <= (i[5:0] - `FMA_LUT_BLUE_BASE) << 1;
        end
      end
    end else if (lutByte && !swRst) begin
      // Only the table changes here, no other setting
      if (lutCnt_ff >= `FMA_LUT_GREEN_BASE && lutCnt_ff < `FMA_LUT_BLUE_BASE) begin
        lutArr[lutCnt_ff] <= hostData[5:0];
      end else begin
        lutArr[lutCnt_ff] <= {1'b0, hostData[4:0]};
      end
    end
  end

  // Lookup used by the pixel expander for 8- and 12-bit pixels
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      lutEntry_ff <= 6'h00;
    end else begin
      lutEntry_ff <= lutArr[{lutSel, lutIdx}];
    end
  end
endmodule

// file: sim/fma_frame_access_assertions.sv
// Purpose: Port checker for frame access commands
// Assumes: One clock, strobes one cycle wide
// Notes: Bound from the bench top file
module fma_frame_access_assertions (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic swRst,
  // Host byte bus
  input wire logic dataCmdSelect,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] hostData,
  input wire logic rdValid_ff,
  input wire logic [7:0] rdData_ff,
  input wire logic [1:0] mode
);
  logic cmdStb;
  logic firstRd_ff;
  assign cmdStb = wrStrobe && !dataCmdSelect;
  // First read byte after a read command
  always @(posedge clk_sys) begin
    if (sys_rst || swRst) firstRd_ff <= 1'b0;
    else if (cmdStb && hostData == 8'h2e) firstRd_ff <= 1'b1;
    else if (rdValid_ff) firstRd_ff <= 1'b0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst || swRst);
  a_write_mode_entry: assert property (cmdStb && hostData == 8'h2c |=> mode == 2'h1)
    else $error("write mode not entered");
  a_read_mode_entry: assert property (cmdStb && hostData == 8'h2e |=> mode == 2'h2)
    else $error("read mode not entered");
  a_table_mode_entry: assert property (cmdStb && hostData == 8'h2d |=> mode == 2'h3)
    else $error("table mode not entered");
  a_other_cmd_ends: assert property (
    cmdStb && !(hostData inside {8'h2c, 8'h2d, 8'h2e}) |=> mode == 2'h0)
    else $error("mode not ended by command");
  a_read_answered: assert property (rdStrobe && dataCmdSelect && mode == 2'h2 |=> rdValid_ff)
    else $error("read byte missing");
  a_no_stray_read: assert property (
    !(rdStrobe && dataCmdSelect && mode == 2'h2) |=> !rdValid_ff)
    else $error("read byte outside read mode");
  a_dummy_first: assert property (rdValid_ff && firstRd_ff |-> rdData_ff == 8'h00)
    else $error("first read byte not dummy");
  a_data_keeps_mode: assert property (!cmdStb && mode != 2'h3 |=> $stable(mode))
    else $error("mode changed without command");
endmodule

// file: sim/fma_host_model.sv
// Purpose: Host model issuing byte writes and reads
// Assumes: Strobes one cycle wide, synchronous to clk_sys
// Notes: Idle bus shows the inverted last byte
module fma_host_model (
  // Clock
  input wire logic clk_sys,
  // Host byte bus
  output logic dataCmdSelect,
  output logic wrStrobe,
  output logic rdStrobe,
  output logic [7:0] hostData
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;
  initial begin
    dataCmdSelect = 1'b1;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    hostData = 8'h00;
  end
  task automatic xfer(input logic dcs, input logic rd, input logic [7:0] b);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    dataCmdSelect <= dcs;
    hostData <= b;
    wrStrobe <= !rd;
    rdStrobe <= rd;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
    hostData <= ~b;
  endtask
endmodule

// file: sim/fma_frame_access_tb.sv
// Purpose: Self-checking bench for frame access commands
// Assumes: Window of 2x2 pixels, 3 or 2 bytes per pixel both ways
// Notes: Read results checked from a queue by a monitor
module fma_frame_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic swRst = 1'b0;
  logic dataCmdSelect, wrStrobe, rdStrobe, wrReady, rdValid_ff;
  logic [7:0] hostData, rdData_ff, colPos, rowPos;
  logic [7:0] colStart = 8'h02, colEnd = 8'h03, rowStart = 8'h05, rowEnd = 8'h06;
  logic [1:0] lutSel = 2'h0, mode;
  logic [3:0] lutIdx = 4'h0;
  logic depthSel = 1'b1;
  logic [1:0] pixFmt = 2'h2;
  logic [2:0] accOrd = 3'h0;
  logic [5:0] lutEntry_ff;
  logic [7:0] frm [12];
  logic [5:0] lutExp [48];
  logic [7:0] expQ [$];
  logic [31:0] lfsr = 32'h4cad5a5a;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 clk_sys = ~clk_sys;
  fma_host_model host (.clk_sys(clk_sys), .dataCmdSelect(dataCmdSelect),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .hostData(hostData));
  fma_frame_access dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .swRst(swRst),
    .dataCmdSelect(dataCmdSelect), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .hostData(hostData), .wrReady(wrReady), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff),
    .colStart(colStart), .colEnd(colEnd), .rowStart(rowStart), .rowEnd(rowEnd),
    .accessOrderControl(accOrd), .colourDepthSelect(depthSel), .pixelFormat(pixFmt),
    .lutSel(lutSel), .lutIdx(lutIdx), .lutEntry_ff(lutEntry_ff),
    .mode(mode), .colPos(colPos), .rowPos(rowPos));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic fail(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) fail(m);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Pixel ring of four: the fifth pixel wraps onto the first
  // Reversed corners land the ring back to front in the read window
  task automatic fill(input int n, input int bpp, input bit rev);
    logic [7:0] b;
    int p;
    for (int k = 0; k < n; k++) begin
      b = rnd();
      p = (k / bpp) % 4;
      frm[(rev ? 3 - p : p) * 3 + k % bpp] = b;
      host.xfer(1'b1, 1'b0, b);
    end
    chk(wrReady === 1'b1, "write side not ready");
  endtask
  task automatic readBack(input int bpp);
    host.xfer(1'b0, 1'b0, 8'h2e);
    expQ.push_back(8'h00);
    host.xfer(1'b1, 1'b1, 8'h00);
    for (int k = 0; k < 4 * bpp; k++) begin
      if (k == 2 * bpp) begin
        #1;
        chk(colPos === colStart && rowPos === rowStart + 8'h01, "read position");
      end
      expQ.push_back(frm[k / bpp * 3 + k % bpp]);
      host.xfer(1'b1, 1'b1, 8'h00);
    end
    repeat (4) @(posedge clk_sys);
    chk(expQ.size() == 0, "read count");
  endtask
  task automatic lutChk(input int i, input logic [5:0] e);
    @(posedge clk_sys);
    lutSel <= 2'(i / 16);
    lutIdx <= 4'(i % 16);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(lutEntry_ff === e, "table entry");
  endtask
  task automatic rampChk();
    for (int i = 0; i < 48; i++) lutChk(i, 6'((i / 16 == 1) ? i % 16 * 4 : i % 16 * 2));
  endtask
  task automatic pulse(input logic hard);
    @(posedge clk_sys);
    if (hard) sys_rst <= 1'b1;
    else swRst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    swRst <= 1'b0;
  endtask
  // Read monitor and run limit
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (rdValid_ff === 1'b1) begin
      if (expQ.size() == 0) fail("unexpected read byte");
      else chk(rdData_ff === expQ.pop_front(), "read byte");
    end
    if (cycles == 5000) begin
      fail("timeout");
      end_sim();
    end
  end
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial begin
    logic [7:0] b;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rampChk();
    $display("test table defaults done");
    host.xfer(1'b0, 1'b0, 8'h2c);
    fill(15, 3, 1'b0);
    readBack(3);
    $display("test write wrap readback done");
    host.gap = 2;
    host.xfer(1'b0, 1'b0, 8'h2c);
    fill(3, 3, 1'b0);
    host.xfer(1'b0, 1'b0, 8'h00);
    host.xfer(1'b1, 1'b0, 8'h5a);
    readBack(3);
    host.xfer(1'b0, 1'b0, 8'h00);
    host.xfer(1'b1, 1'b1, 8'h00);
    host.gap = 0;
    $display("test abort and slow host done");
    host.xfer(1'b0, 1'b0, 8'h2d);
    for (int i = 0; i < 48; i++) begin
      b = rnd() & ((i / 16 == 1) ? 8'h3f : 8'h1f);
      lutExp[i] = b[5:0];
      host.xfer(1'b1, 1'b0, b);
    end
    repeat (2) @(posedge clk_sys);
    #1;
    chk(mode === 2'h0, "table load end");
    pulse(1'b0);
    for (int i = 0; i < 48; i++) lutChk(i, lutExp[i]);
    readBack(3);
    pulse(1'b1);
    rampChk();
    readBack(3);
    $display("test table load and resets done");
    // 2-byte pixels both ways; write window at the far corner, both axes reversed
    @(posedge clk_sys);
    pixFmt <= 2'h1;
    depthSel <= 1'b0;
    accOrd <= 3'h3;
    colStart <= 8'hac;
    colEnd <= 8'had;
    rowStart <= 8'he9;
    rowEnd <= 8'hea;
    host.xfer(1'b0, 1'b0, 8'h2c);
    @(posedge clk_sys);
    accOrd <= 3'h0;
    colStart <= 8'h02;
    colEnd <= 8'h03;
    rowStart <= 8'h05;
    rowEnd <= 8'h06;
    fill(8, 2, 1'b1);
    readBack(2);
    $display("test reversed order and 16-bit readback done");
    end_sim();
  end
endmodule
bind fma_frame_access fma_frame_access_assertions chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .swRst(swRst), .dataCmdSelect(dataCmdSelect), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
  .hostData(hostData), .rdValid_ff(rdValid_ff), .rdData_ff(rdData_ff), .mode(mode));
